/* File: rtl/ddc_device.sv */
// What this block does
// - Outputs clamped until supply good and data written
// - Per-channel power bits, all off after reset
// - Powered-down channel: pin grounded, amplifier disconnected
// - Clamp mode: short limits current, sets flag
// - Clamp mode: flag clears when short goes
// - Power-down mode: short kills channel, sets flag
// - Host rewrites power bit to restore channel
// - Thermal guard disarmed after reset, host arms
// - Armed overtemperature kills both channels, sets flag
// - Reference off after reset, host powers up
// - Host leaves reference off with external source
// - 24-bit word, sampled on falling clock
// - Host drives clock, data and frame sync
// - Update at word end if load strobe held low, or on load strobe
// - Registers readable back over serial link
// - Select 011 address 001 holds control bits
// - Select 010 holds power and status bits
// - Status flags read-only, writes ignored
// - Clamp mode is the reset default
`timescale 1ns/1ps
`include "ddc_params.svh"
module ddc_device #(
    parameter int DATA_BITS = 16
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    ddc_link_if.dev LNK,
    input wire logic SUPPLY_OK,
    input wire logic OVERTEMP,
    input wire logic [1:0] SHORT_DET,
    output logic [15:0] DAC_A_CODE,
    output logic [15:0] DAC_B_CODE,
    output logic [1:0] OUT_CLAMP,
    output logic [1:0] AMP_CONNECT,
    output logic [1:0] CUR_LIMIT,
    output logic VREF_ON
);
    import ddc_pkg::*;

    if (DATA_BITS < 12 || DATA_BITS > 16) begin : g_bad_bits
        $error("DATA_BITS must be 12 to 16");
    end

    localparam int PU_POS [2] = '{`DDC_PWR_PUA, `DDC_PWR_PUB};
    localparam int SF_POS [2] = '{`DDC_PWR_SA, `DDC_PWR_SB};

    // Pins and analog detectors all come from other domains
    logic [7:0] meta_q;
    logic [7:0] pin_q;
    logic [7:0] prev_q;
    wire [7:0] pin_raw = {SUPPLY_OK, OVERTEMP, SHORT_DET, LNK.output_load_strobe_n, LNK.serial_data_in, LNK.sync_n, LNK.sclk};
    wire sclk_fall = prev_q[0] & ~pin_q[0];
    wire sclk_rise = ~prev_q[0] & pin_q[0];
    wire in_frame = ~pin_q[1];
    wire frame_start = prev_q[1] & ~pin_q[1];
    wire frame_end = ~prev_q[1] & pin_q[1];
    wire serial_data_in_s = pin_q[2];
    wire output_load_strobe_low = ~pin_q[3];
    wire output_load_strobe_fall = prev_q[3] & ~pin_q[3];
    wire [1:0] short_s = pin_q[5:4];
    wire ot_s = pin_q[6];
    wire supply_s = pin_q[7];

    logic [23:0] shift_q;
    logic [4:0] bits_q;
    logic [23:0] txsh_q;
    logic rd_pend_q;
    logic [23:0] rd_word_q;
    logic [1:0] pu_q;
    logic [1:0] flag_q;
    logic vref_q;
    logic ot_flag_q;
    logic arm_q;
    logic clamp_q;
    logic clrsel_q;
    logic sdodis_q;
    logic valid_q;
    logic [DATA_BITS-1:0] in_q [2];
    logic [DATA_BITS-1:0] dac_q [2];
    logic [1:0] clamp_out_q;
    logic [1:0] amp_q;
    logic [1:0] curlim_q;

    // Words that are not exactly 24 bits long are dropped
    wire [4:0] bits_d = (bits_q == 5'd25) ? bits_q : 5'(bits_q + 5'd1);
    wire word_ok = frame_end & (bits_q == 5'(`DDC_WORD_BITS));
    wire is_read = shift_q[`DDC_RW_BIT];
    wire [2:0] sel = shift_q[21:19];
    wire [2:0] addr = shift_q[18:16];
    wire [15:0] data = shift_q[15:0];
    wire wr_ok = word_ok & ~is_read;
    wire dac_wr = wr_ok & (sel == `DDC_SEL_DAC);
    wire pwr_wr = wr_ok & (sel == `DDC_SEL_PWR);
    wire ctl_sel = wr_ok & (sel == `DDC_SEL_CTRL);
    wire ctl_wr = ctl_sel & (addr == `DDC_CA_SET);
    wire clr_cmd = ctl_sel & (addr == `DDC_CA_CLEAR);
    wire load_cmd = ctl_sel & (addr == `DDC_CA_LOAD);
    wire wr_a = dac_wr & (addr == `DDC_ADDR_A || addr == `DDC_ADDR_ALL);
    wire wr_b = dac_wr & (addr == `DDC_ADDR_B || addr == `DDC_ADDR_ALL);
    wire [1:0] wr_ch = {wr_b, wr_a};
    // Auto update needs the strobe held low through the frame end
    wire upd_all = load_cmd | output_load_strobe_fall | (dac_wr & output_load_strobe_low);
    wire [15:0] clr_code = clrsel_q ? `DDC_CLR_MID : `DDC_CLR_ZERO;
    wire ot_trip = arm_q & ot_s;

    wire [1:0] pu_d;
    wire [1:0] flag_d;
    wire [1:0] drive_d;
    wire [1:0] curlim_d;
    wire [DATA_BITS-1:0] in_d [2];
    wire [DATA_BITS-1:0] dac_d [2];
    wire [15:0] in_rb [2];

    for (genvar i = 0; i < 2; i++) begin : g_ch
        // A short is only seen while the channel's power bit is set
        wire short_hit = short_s[i] & pu_q[i];
        wire kill = (short_hit & ~clamp_q) | ot_trip;
        // Hardware power-down wins over a host write in the same cycle
        assign pu_d[i] = kill ? 1'b0 : (pwr_wr ? data[PU_POS[i]] : pu_q[i]);
        // Set wins over any clear
        assign flag_d[i] = short_hit ? 1'b1 :
            ((clamp_q | (pwr_wr & data[PU_POS[i]])) ? 1'b0 : flag_q[i]);
        assign drive_d[i] = pu_q[i] & valid_q & supply_s;
        assign curlim_d[i] = short_hit & clamp_q;
        assign in_d[i] = wr_ch[i] ? data[15 -: DATA_BITS] : in_q[i];
        assign dac_d[i] = clr_cmd ? clr_code[15 -: DATA_BITS] : (upd_all ? in_d[i] : dac_q[i]);
        assign in_rb[i] = {in_q[i], {(16 - DATA_BITS){1'b0}}};
    end

    wire [15:0] pwr_word = (16'(pu_q[0]) << `DDC_PWR_PUA) | (16'(pu_q[1]) << `DDC_PWR_PUB) |
        (16'(vref_q) << `DDC_PWR_REF) | (16'(ot_flag_q) << `DDC_PWR_OT) |
        (16'(flag_q[0]) << SF_POS[0]) | (16'(flag_q[1]) << SF_POS[1]);
    wire [15:0] ctl_word = (16'(arm_q) << `DDC_CTL_ARM) | (16'(clamp_q) << `DDC_CTL_CLAMP) |
        (16'(clrsel_q) << `DDC_CTL_CLRSEL) | (16'(sdodis_q) << `DDC_CTL_SDODIS);
    wire rb_dac = (sel == `DDC_SEL_DAC);
    wire rb_pwr = (sel == `DDC_SEL_PWR);
    wire rb_ctl = (sel == `DDC_SEL_CTRL) & (addr == `DDC_CA_SET);
    wire [15:0] rb_val = rb_dac ? in_rb[addr == `DDC_ADDR_B] :
        rb_pwr ? pwr_word :
        rb_ctl ? ctl_word : 16'h0000;
    wire ot_flag_d = ot_trip | (ot_flag_q & ~(pwr_wr & ~ot_s));
    // Brownout drops the data-valid latch, so outputs clamp again
    wire valid_d = supply_s & (valid_q | dac_wr);

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            meta_q <= `DDC_PIN_RST;
            pin_q <= `DDC_PIN_RST;
            prev_q <= `DDC_PIN_RST;
        end else begin
            meta_q <= pin_raw;
            pin_q <= meta_q;
            prev_q <= pin_q;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            shift_q <= 24'h00_0000;
            bits_q <= 5'd0;
        end else if (frame_start) begin
            bits_q <= 5'd0;
        end else if (in_frame && sclk_fall) begin
            shift_q <= {shift_q[22:0], serial_data_in_s};
            bits_q <= bits_d;
        end
    end

    // Read data leaves on the frame after the read request
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            rd_pend_q <= 1'b0;
            rd_word_q <= 24'h00_0000;
            txsh_q <= 24'h00_0000;
        end else begin
            if (word_ok && is_read) begin
                rd_pend_q <= 1'b1;
                rd_word_q <= {shift_q[23:16], rb_val};
            end else if (frame_start) begin
                rd_pend_q <= 1'b0;
            end
            if (frame_start) begin
                txsh_q <= (rd_pend_q && !sdodis_q) ? rd_word_q : 24'h00_0000;
            end else if (in_frame && sclk_rise) begin
                txsh_q <= {txsh_q[22:0], 1'b0};
            end
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            pu_q <= 2'b00;
            flag_q <= 2'b00;
            ot_flag_q <= 1'b0;
            vref_q <= 1'b0;
            arm_q <= 1'b0;
            clamp_q <= `DDC_CLAMP_RST;
            clrsel_q <= 1'b0;
            sdodis_q <= 1'b0;
            valid_q <= 1'b0;
        end else begin
            pu_q <= pu_d;
            flag_q <= flag_d;
            ot_flag_q <= ot_flag_d;
            valid_q <= valid_d;
            if (pwr_wr) begin
                vref_q <= data[`DDC_PWR_REF];
            end
            if (ctl_wr) begin
                arm_q <= data[`DDC_CTL_ARM];
                clamp_q <= data[`DDC_CTL_CLAMP];
                clrsel_q <= data[`DDC_CTL_CLRSEL];
                sdodis_q <= data[`DDC_CTL_SDODIS];
            end
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            in_q <= '{default: '0};
            dac_q <= '{default: '0};
            clamp_out_q <= 2'b11;
            amp_q <= 2'b00;
            curlim_q <= 2'b00;
        end else begin
            in_q <= in_d;
            dac_q <= dac_d;
            clamp_out_q <= ~drive_d;
            amp_q <= drive_d;
            curlim_q <= curlim_d;
        end
    end

    assign LNK.sdo = txsh_q[23];
    assign DAC_A_CODE = {dac_q[0], {(16 - DATA_BITS){1'b0}}};
    assign DAC_B_CODE = {dac_q[1], {(16 - DATA_BITS){1'b0}}};
    assign OUT_CLAMP = clamp_out_q;
    assign AMP_CONNECT = amp_q;
    assign CUR_LIMIT = curlim_q;
    assign VREF_ON = vref_q;
endmodule : ddc_device

/* File: rtl/ddc_host.sv */
`timescale 1ns/1ps
`include "ddc_params.svh"
module ddc_host #(
    parameter int HALF_CYC = `DDC_HALF_CYC
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    ddc_link_if.host LNK
);
    import ddc_pkg::*;

    // Device needs about six cycles of round trip through both synchronisers
    if (HALF_CYC < 8 || HALF_CYC > 255) begin : g_bad_half
        $error("HALF_CYC must be 8 to 255");
    end

    localparam logic [7:0] HALF_M1 = 8'(HALF_CYC - 1);

    ddc_hstate_e st_q;
    logic [7:0] cnt_q;
    logic [4:0] bit_q;
    logic phase_q;
    ddc_word_t txsh_q;
    ddc_word_t rxsh_q;
    ddc_word_t rx_q;
    logic rx_valid_q;
    logic sclk_q;
    logic sync_n_q;
    logic serial_data_in_q;
    logic hold_q;
    logic [8:0] pulse_q;
    logic sdo_m_q;
    logic sdo_q;
    logic output_load_strobe_n_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;

    wire access = PSEL & PENABLE & ~pready_q;
    wire fire = PSEL & PENABLE & pready_q;
    wire a_tx = (PADDR == `DDC_OFS_TX);
    wire a_st = (PADDR == `DDC_OFS_STAT);
    wire a_rx = (PADDR == `DDC_OFS_RX);
    wire a_ld = (PADDR == `DDC_OFS_OUTPUT_LOAD_STROBE);
    wire busy = (st_q != HS_IDLE);
    wire bad = ~(a_tx | a_st | a_rx | a_ld) | (PWRITE & (a_st | a_rx)) | (PWRITE & a_tx & busy);
    wire start = fire & PWRITE & a_tx & ~busy;
    wire rx_clr = fire & ~PWRITE & a_rx;
    wire frame_done = (st_q == HS_SHIFT) && (cnt_q == 8'd0) && phase_q && (bit_q == 5'd23);
    wire [31:0] rd_val = a_st ? {30'h0000_0000, rx_valid_q, busy} :
        a_rx ? {8'h00, rx_q} :
        a_ld ? {31'h0000_0000, hold_q} : 32'h0000_0000;

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= access;
            pslverr_q <= access & bad;
            prdata_q <= (access && !PWRITE && !bad) ? rd_val : 32'h0000_0000;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            hold_q <= 1'b0;
            pulse_q <= 9'd0;
            rx_valid_q <= 1'b0;
            sdo_m_q <= 1'b0;
            sdo_q <= 1'b0;
            output_load_strobe_n_q <= 1'b1;
        end else begin
            // Registered so the strobe pin cannot glitch
            output_load_strobe_n_q <= ~(hold_q | (pulse_q != 9'd0));
            sdo_m_q <= LNK.sdo;
            sdo_q <= sdo_m_q;
            // A finished frame wins over a read of the receive word
            rx_valid_q <= frame_done | (rx_valid_q & ~rx_clr);
            if (fire && PWRITE && a_ld) begin
                hold_q <= PWDATA[0];
                pulse_q <= PWDATA[1] ? 9'(2 * HALF_CYC) : 9'd0;
            end else if (pulse_q != 9'd0) begin
                pulse_q <= 9'(pulse_q - 9'd1);
            end
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            st_q <= HS_IDLE;
            cnt_q <= 8'd0;
            bit_q <= 5'd0;
            phase_q <= 1'b0;
            txsh_q <= 24'h00_0000;
            rxsh_q <= 24'h00_0000;
            rx_q <= 24'h00_0000;
            sclk_q <= 1'b1;
            sync_n_q <= 1'b1;
            serial_data_in_q <= 1'b0;
        end else begin
            case (st_q)
                HS_IDLE: begin
                    if (start) begin
                        txsh_q <= PWDATA[23:0];
                        serial_data_in_q <= PWDATA[23];
                        sync_n_q <= 1'b0;
                        cnt_q <= HALF_M1;
                        bit_q <= 5'd0;
                        phase_q <= 1'b0;
                        st_q <= HS_SHIFT;
                    end
                end
                HS_SHIFT: begin
                    if (cnt_q != 8'd0) begin
                        cnt_q <= 8'(cnt_q - 8'd1);
                    end else begin
                        cnt_q <= HALF_M1;
                        if (!phase_q) begin
                            // Device samples on this falling edge
                            sclk_q <= 1'b0;
                            rxsh_q <= {rxsh_q[22:0], sdo_q};
                            phase_q <= 1'b1;
                        end else if (bit_q == 5'd23) begin
                            sclk_q <= 1'b1;
                            sync_n_q <= 1'b1;
                            rx_q <= rxsh_q;
                            st_q <= HS_GAP;
                        end else begin
                            sclk_q <= 1'b1;
                            txsh_q <= {txsh_q[22:0], 1'b0};
                            serial_data_in_q <= txsh_q[22];
                            bit_q <= 5'(bit_q + 5'd1);
                            phase_q <= 1'b0;
                        end
                    end
                end
                HS_GAP: begin
                    if (cnt_q != 8'd0) begin
                        cnt_q <= 8'(cnt_q - 8'd1);
                    end else begin
                        st_q <= HS_IDLE;
                    end
                end
                default: begin
                    st_q <= HS_IDLE;
                end
            endcase
        end
    end

    assign LNK.sclk = sclk_q;
    assign LNK.sync_n = sync_n_q;
    assign LNK.serial_data_in = serial_data_in_q;
    assign LNK.output_load_strobe_n = output_load_strobe_n_q;
    assign PRDATA = prdata_q;
    assign PREADY = pready_q;
    assign PSLVERR = pslverr_q;
endmodule : ddc_host

/* File: rtl/ddc_link_if.sv */
`timescale 1ns/1ps
interface ddc_link_if;
    logic sclk;
    logic sync_n;
    logic serial_data_in;
    logic sdo;
    logic output_load_strobe_n;
    modport dev (input sclk, input sync_n, input serial_data_in, input output_load_strobe_n, output sdo);
    modport host (output sclk, output sync_n, output serial_data_in, output output_load_strobe_n, input sdo);
endinterface : ddc_link_if

/* File: rtl/ddc_params.svh */
`ifndef DDC_PARAMS_SVH
`define DDC_PARAMS_SVH
`define DDC_WORD_BITS 24
`define DDC_RW_BIT 23
`define DDC_SEL_DAC 3'h0
`define DDC_SEL_PWR 3'h2
`define DDC_SEL_CTRL 3'h3
`define DDC_ADDR_A 3'h0
`define DDC_ADDR_B 3'h2
`define DDC_ADDR_ALL 3'h4
`define DDC_CA_NOP 3'h0
`define DDC_CA_SET 3'h1
`define DDC_CA_CLEAR 3'h4
`define DDC_CA_LOAD 3'h5
`define DDC_PWR_PUA 0
`define DDC_PWR_PUB 2
`define DDC_PWR_REF 4
`define DDC_PWR_OT 5
`define DDC_PWR_SA 7
`define DDC_PWR_SB 9
`define DDC_CTL_SDODIS 0
`define DDC_CTL_CLRSEL 1
`define DDC_CTL_CLAMP 2
`define DDC_CTL_ARM 3
`define DDC_CLAMP_RST 1'b1
`define DDC_CLR_ZERO 16'h0000
`define DDC_CLR_MID 16'h8000
`define DDC_PIN_RST 8'h0B
`define DDC_HALF_CYC 8
`define DDC_OFS_TX 12'h000
`define DDC_OFS_STAT 12'h004
`define DDC_OFS_RX 12'h008
`define DDC_OFS_OUTPUT_LOAD_STROBE 12'h00C
`endif

/* File: rtl/ddc_pkg.sv */
package ddc_pkg;
    typedef logic [23:0] ddc_word_t;
    typedef enum logic [2:0] {
        HS_IDLE = 3'b001,
        HS_SHIFT = 3'b010,
        HS_GAP = 3'b100
    } ddc_hstate_e;
endpackage : ddc_pkg

/* File: tb/ddc_asserts.sv */
`timescale 1ns/1ps
module ddc_asserts (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic sclk,
    input wire logic sync_n,
    input wire logic SUPPLY_OK,
    input wire logic [1:0] SHORT_DET,
    input wire logic [1:0] OUT_CLAMP,
    input wire logic [1:0] AMP_CONNECT,
    input wire logic [1:0] CUR_LIMIT,
    input wire logic VREF_ON
);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RST);
    // Falling serial edges seen in the current frame
    logic [5:0] fall_cnt_q;
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            fall_cnt_q <= 6'h00;
        end else if (sync_n) begin
            fall_cnt_q <= 6'h00;
        end else if ($fell(sclk)) begin
            fall_cnt_q <= fall_cnt_q + 6'h01;
        end
    end
    AST_PIN_EXCL: assert property ((AMP_CONNECT & OUT_CLAMP) == 2'h0)
        else $error("amplifier on a clamped pin");
    AST_RST_STATE: assert property ($fell(RST) |->
        OUT_CLAMP == 2'h3 && AMP_CONNECT == 2'h0 && CUR_LIMIT == 2'h0 && !VREF_ON)
        else $error("outputs not in start-up state");
    AST_NO_SUPPLY: assert property ((!SUPPLY_OK) [*6] |-> AMP_CONNECT == 2'h0)
        else $error("amplifier on without supply");
    AST_AMP_A_SUPPLY: assert property ($rose(AMP_CONNECT[0]) |-> $past(SUPPLY_OK, 2))
        else $error("channel A connected without supply");
    AST_AMP_B_SUPPLY: assert property ($rose(AMP_CONNECT[1]) |-> $past(SUPPLY_OK, 2))
        else $error("channel B connected without supply");
    AST_LIMIT_CAUSE: assert property ($rose(CUR_LIMIT[0]) |-> $past(SHORT_DET[0], 2))
        else $error("current limit without short");
    AST_LIMIT_GONE: assert property ((SHORT_DET == 2'h0) [*6] |-> CUR_LIMIT == 2'h0)
        else $error("current limit stays after short");
    AST_IDLE_HIGH: assert property (sync_n |-> sclk)
        else $error("serial clock low outside frame");
    AST_LEAD: assert property ($fell(sync_n) |-> sclk [*4] ##[1:16] !sclk)
        else $error("bad first clock edge of frame");
    AST_FRAME_24: assert property ($rose(sync_n) |-> fall_cnt_q == 6'h18)
        else $error("frame not 24 bits");
endmodule : ddc_asserts

/* File: tb/dual_dac_power_fault_control_tb.sv */
`timescale 1ns/1ps
module dual_dac_power_fault_control_tb;
    import ddc_pkg::*;
    typedef struct {logic [23:0] wr; logic [23:0] rb; logic [15:0] exp; logic [15:0] msk;} ddc_row_s;
    logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, supply_ok, overtemp, vref_on, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] short_det, out_clamp, amp_connect, cur_limit;
    logic [15:0] dac_a, dac_b;
    int n_mismatch = 0;
    int n_tests = 0;
    ddc_row_s rows [3] = '{'{24'h19_0004, 24'h99_0000, 16'h0004, 16'h000F},
        '{24'h10_02B5, 24'h90_0000, 16'h0015, 16'h02B5}, '{24'h00_1234, 24'h80_0000, 16'h1234, 16'hFFFF}};
    ddc_link_if lnk ();
    ddc_host ddc_host_inst (.SYS_CLK(sys_clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .LNK(lnk.host));
    ddc_device ddc_device_inst (.SYS_CLK(sys_clk), .RST(rst), .LNK(lnk.dev), .SUPPLY_OK(supply_ok),
        .OVERTEMP(overtemp), .SHORT_DET(short_det), .DAC_A_CODE(dac_a), .DAC_B_CODE(dac_b),
        .OUT_CLAMP(out_clamp), .AMP_CONNECT(amp_connect), .CUR_LIMIT(cur_limit), .VREF_ON(vref_on));
    ddc_asserts ddc_asserts_inst (.SYS_CLK(sys_clk), .RST(rst), .sclk(lnk.sclk), .sync_n(lnk.sync_n),
        .SUPPLY_OK(supply_ok), .SHORT_DET(short_det), .OUT_CLAMP(out_clamp),
        .AMP_CONNECT(amp_connect), .CUR_LIMIT(cur_limit), .VREF_ON(vref_on));
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic give_verdict();
        if (n_mismatch == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [23:0] g, input logic [23:0] e);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, g, e);
        end
    endtask : chk
    // Pin state packed as clamp, amp, limit, vref
    task automatic st(input logic [6:0] e);
        chk({17'h0, out_clamp, amp_connect, cur_limit, vref_on}, {17'h0, e});
    endtask : st
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            n_mismatch++;
            give_verdict();
        end
    endtask : apb
    task automatic send(input logic [23:0] w);
        int n;
        n = 0;
        apb(1'b1, 12'h000, {8'h00, w});
        do begin
            apb(1'b0, 12'h004, 32'h0000_0000);
            n++;
        end while (rd[0] !== 1'b0 && n < 300);
        if (n >= 300) begin
            n_mismatch++;
            give_verdict();
        end
        // Leaves the frame gap and the device's synchroniser delay behind
        repeat (12) @(posedge sys_clk);
    endtask : send
    task automatic rb(input logic [23:0] c, input logic [15:0] e, input logic [15:0] m);
        send(c);
        send(24'h18_0000);
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk(rd[23:0] & {8'hFF, m}, {c[23:16], e & m});
    endtask : rb
    initial begin
        int n;
        {psel, penable, pwrite, overtemp} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        short_det = 2'h0;
        supply_ok = 1'b1;
        rst = 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        st(7'h60);
        rb(24'h90_0000, 16'h0000, 16'h02B5);
        rb(24'h99_0000, 16'h0004, 16'h000F);
        foreach (rows[i]) begin
            send(rows[i].wr);
            rb(rows[i].rb, rows[i].exp, rows[i].msk);
        end
        st(7'h19);
        chk({8'h00, dac_a}, 24'h00_0000);
        apb(1'b1, 12'h00C, 32'h0000_0002);
        n = 0;
        while (dac_a !== 16'h1234 && n < 40) begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 40) begin
            n_mismatch++;
            give_verdict();
        end
        chk({8'h00, dac_a}, 24'h00_1234);
        apb(1'b1, 12'h00C, 32'h0000_0001);
        send(24'h02_5678);
        chk({8'h00, dac_b}, 24'h00_5678);
        apb(1'b1, 12'h00C, 32'h0000_0000);
        overtemp <= 1'b1;
        repeat (10) @(posedge sys_clk);
        st(7'h19);
        rb(24'h90_0000, 16'h0015, 16'h02B5);
        overtemp <= 1'b0;
        short_det <= 2'h1;
        repeat (10) @(posedge sys_clk);
        st(7'h1B);
        rb(24'h90_0000, 16'h0095, 16'h02B5);
        short_det <= 2'h0;
        repeat (10) @(posedge sys_clk);
        st(7'h19);
        rb(24'h90_0000, 16'h0015, 16'h02B5);
        send(24'h19_0008);
        short_det <= 2'h2;
        repeat (10) @(posedge sys_clk);
        st(7'h49);
        rb(24'h90_0000, 16'h0211, 16'h02B5);
        short_det <= 2'h0;
        send(24'h10_0015);
        st(7'h19);
        rb(24'h90_0000, 16'h0015, 16'h02B5);
        overtemp <= 1'b1;
        repeat (10) @(posedge sys_clk);
        st(7'h61);
        rb(24'h90_0000, 16'h0030, 16'h02B5);
        overtemp <= 1'b0;
        send(24'h10_0015);
        supply_ok <= 1'b0;
        repeat (10) @(posedge sys_clk);
        st(7'h61);
        supply_ok <= 1'b1;
        repeat (10) @(posedge sys_clk);
        // Supply back alone must not reconnect: a fresh data word is needed
        st(7'h61);
        send(24'h02_5678);
        st(7'h19);
        // Mid-run reset must bring back the start-up defaults
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        st(7'h60);
        rb(24'h99_0000, 16'h0004, 16'h000F);
        rb(24'h90_0000, 16'h0000, 16'h02B5);
        apb(1'b1, 12'h010, 32'h0000_0000);
        chk({23'h0, er}, 24'h00_0001);
        give_verdict();
    end
endmodule : dual_dac_power_fault_control_tb
